// file: hw/bcc_params.svh
// Constants for the battery charge control block
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
`define BCC_CLK_MHZ     40
`define BCC_T_LOWV_US   25000
`define BCC_T_RCH_US    62500
`define BCC_T_DET_US    250000
`define BCC_LOWV_CYC    (`BCC_T_LOWV_US * `BCC_CLK_MHZ)
`define BCC_RCH_CYC     (`BCC_T_RCH_US * `BCC_CLK_MHZ)
`define BCC_DET_CYC     (`BCC_T_DET_US * `BCC_CLK_MHZ)
`define BCC_A_CTRL      8'h00
`define BCC_A_STAT      8'h04
`define BCC_A_IRQ       8'h08
`define BCC_A_MASK      8'h0C
`define BCC_A_TIMER     8'h10
`define BCC_CTRL_RST    16'h0080
`define BCC_CTRL_EN     0
`define BCC_CTRL_PRE    1
`define BCC_CTRL_TERM   3
`define BCC_CTRL_SCALE  5
`define BCC_CTRL_ILIM   7
`define BCC_EV_DONE     0
`define BCC_EV_REMOVED  1
`define BCC_EV_INSERTED 2
`define BCC_EV_START    3
`endif

// file: hw/bcc_pkg.sv
// Types shared by the battery charge control modules
package bcc_pkg;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001, ST_SC = 9'h002, ST_PRE = 9'h004,
        ST_FAST = 9'h008, ST_CV = 9'h010, ST_DONE = 9'h020,
        ST_DET = 9'h040, ST_INS = 9'h080, ST_FULL = 9'h100
    } bcc_state_e;

    typedef struct packed {
        bcc_state_e  st;
        logic [23:0] win;
        logic        flag;
        logic [4:0]  acc;
        logic [15:0] tmr;
        logic [3:0]  evt;
        logic        sc_src;
        logic        q2_src;
        logic        sink;
        logic        chg_on;
        logic        cv;
        logic        reduce;
        logic [4:0]  cur;
        logic [4:0]  term;
    } bcc_core_s;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0]  irq;
        logic [3:0]  mask;
        logic [15:0] rdata;
        logic        irq_out;
    } bcc_reg_s;

    typedef struct packed {
        logic [23:0] cnt;
        logic        stable;
    } bcc_dg_s;
endpackage

// file: hw/bcc_ctl_if.sv
// Control fields and status passed between core and register file
`timescale 1ns/100ps
interface bcc_ctl_if;
    logic        en;
    logic [1:0]  pre_sel;
    logic [1:0]  term_sel;
    logic [1:0]  scale;
    logic        ilim_500;
    logic [3:0]  evt;
    logic [15:0] stat;
    logic [15:0] timer;
    modport regs (output en, pre_sel, term_sel, scale, ilim_500,
                  input evt, stat, timer);
    modport core (input en, pre_sel, term_sel, scale, ilim_500,
                  output evt, stat, timer);
endinterface

// file: hw/bcc_deglitch.sv
// Level deglitch filter: output follows input after it holds for CYC cycles
`timescale 1ns/100ps
module bcc_deglitch #(
    parameter int CYC = 1000
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Level
    input  wire logic raw,
    output logic      stable
);
    bcc_pkg::bcc_dg_s s;
    bcc_pkg::bcc_dg_s n;

    always_comb
    begin
        n = s;
        if (raw == s.stable)
        begin
            n.cnt = '0;
        end
        else if (s.cnt == 24'(CYC - 1))
        begin
            n.cnt    = '0;
            n.stable = raw;
        end
        else
        begin
            n.cnt = s.cnt + 24'd1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= n;
    end

    assign stable = s.stable;
endmodule // bcc_deglitch

// file: hw/bcc_regs.sv
// Register file with sticky interrupt status and mask
`timescale 1ns/100ps
`include "bcc_params.svh"
module bcc_regs (
    // Clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             irq,
    // Core side
    bcc_ctl_if.regs          ctl
);
    bcc_pkg::bcc_reg_s s;
    bcc_pkg::bcc_reg_s n;
    logic [3:0]        clr;

    always_comb
    begin
        n       = s;
        clr     = '0;
        n.rdata = '0;
        if (reg_wr && reg_addr == `BCC_A_CTRL)
            n.ctrl = {8'h00, reg_wdata[7:0]};
        if (reg_wr && reg_addr == `BCC_A_MASK)
            n.mask = reg_wdata[3:0];
        if (reg_wr && reg_addr == `BCC_A_IRQ)
            clr = reg_wdata[3:0];
        // A new event in the clearing cycle stays set
        n.irq = (s.irq & ~clr) | ctl.evt;
        if (reg_rd)
        begin
            case (reg_addr)
                `BCC_A_CTRL:  n.rdata = s.ctrl;
                `BCC_A_STAT:  n.rdata = ctl.stat;
                `BCC_A_IRQ:   n.rdata = {12'h000, s.irq};
                `BCC_A_MASK:  n.rdata = {12'h000, s.mask};
                `BCC_A_TIMER: n.rdata = ctl.timer;
                default:      n.rdata = '0;
            endcase
        end
        n.irq_out = |(n.irq & n.mask);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s      <= '0;
            s.ctrl <= `BCC_CTRL_RST;
        end
        else
            s <= n;
    end

    assign reg_rdata    = s.rdata;
    assign irq          = s.irq_out;
    assign ctl.en       = s.ctrl[`BCC_CTRL_EN];
    assign ctl.pre_sel  = s.ctrl[`BCC_CTRL_PRE +: 2];
    assign ctl.term_sel = s.ctrl[`BCC_CTRL_TERM +: 2];
    assign ctl.scale    = s.ctrl[`BCC_CTRL_SCALE +: 2];
    assign ctl.ilim_500 = s.ctrl[`BCC_CTRL_ILIM];
endmodule // bcc_regs

// file: hw/bcc_charge_ctrl.sv
// Charge sequencer with battery detection, current selection and timer
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "bcc_params.svh"
module bcc_charge_ctrl #(
    parameter int LOWV_CYC = `BCC_LOWV_CYC,
    parameter int RCH_CYC  = `BCC_RCH_CYC,
    parameter int DET_CYC  = `BCC_DET_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             irq,
    // Analog comparators and loop status
    input  wire logic        vbat_gt_sc,
    input  wire logic        vbat_gt_lowv,
    input  wire logic        vbat_ge_reg,
    input  wire logic        vbat_lt_rch,
    input  wire logic        ibat_lt_term,
    input  wire logic        tj_hot,
    input  wire logic        load_priority_mode,
    input  wire logic        low_input_loop,
    input  wire logic [4:0]  chg_ratio,
    // Current source and switch controls
    output logic             sc_test_src,
    output logic             battery_path_switch,
    output logic             detect_sink_current,
    output logic             charge_on,
    output logic             cv_hold,
    output logic             cur_reduce,
    output logic [4:0]       cur_code,
    output logic [4:0]       term_code,
    output logic             ilim_500,
    output logic             charging_flag
);
    bcc_pkg::bcc_core_s s;
    bcc_pkg::bcc_core_s n;
    logic [4:0]         fast_lvl;
    logic [4:0]         pre_lvl;
    logic [4:0]         term_lvl;
    logic [5:0]         acc_sum;
    logic               win_end;
    logic               lowv_dg;
    logic               rch_dg;
    logic               loops;

    bcc_ctl_if ctl ();

    bcc_regs u_regs (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .irq       (irq),
        .ctl       (ctl.regs)
    );

    // Filters both directions of the pre-charge/fast crossing
    bcc_deglitch #(.CYC(LOWV_CYC)) u_dg_lowv (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .raw     (vbat_gt_lowv),
        .stable  (lowv_dg)
    );

    bcc_deglitch #(.CYC(RCH_CYC)) u_dg_rch (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .raw     (vbat_lt_rch),
        .stable  (rch_dg)
    );

    // Levels in sixteenths of the resistor-set current
    assign fast_lvl = {1'b0, ctl.scale, 2'b00} + 5'd4;
    assign pre_lvl  = fast_lvl >> (3'd4 - {1'b0, ctl.pre_sel});
    assign term_lvl = fast_lvl >> (3'd4 - {1'b0, ctl.term_sel});
    assign loops    = tj_hot | load_priority_mode | low_input_loop;
    assign win_end  = (s.win == 24'(DET_CYC - 1));
    assign acc_sum  = {1'b0, s.acc} + {1'b0, chg_ratio};

    always_comb
    begin
        n       = s;
        n.evt   = '0;
        n.win   = s.win + 24'd1;
        case (s.st)
            bcc_pkg::ST_IDLE:
            begin
                if (ctl.en)
                begin
                    n.st                = bcc_pkg::ST_SC;
                    n.flag              = 1'b1;
                    n.tmr               = '0;
                    n.acc               = '0;
                    n.evt[`BCC_EV_START] = 1'b1;
                end
            end
            bcc_pkg::ST_SC:
            begin
                if (vbat_gt_sc)
                    n.st = bcc_pkg::ST_PRE;
            end
            bcc_pkg::ST_PRE:
            begin
                if (lowv_dg)
                    n.st = bcc_pkg::ST_FAST;
            end
            bcc_pkg::ST_FAST:
            begin
                if (!lowv_dg)
                    n.st = bcc_pkg::ST_PRE;
                else if (vbat_ge_reg)
                    n.st = bcc_pkg::ST_CV;
            end
            bcc_pkg::ST_CV:
            begin
                // Current below threshold means nothing while a loop throttles it
                if (ibat_lt_term && !loops)
                begin
                    n.st                = bcc_pkg::ST_DONE;
                    n.flag              = 1'b0;
                    n.evt[`BCC_EV_DONE] = 1'b1;
                end
            end
            bcc_pkg::ST_DONE:
            begin
                if (rch_dg)
                    n.st = bcc_pkg::ST_DET;
            end
            bcc_pkg::ST_DET:
            begin
                if (!vbat_gt_lowv)
                begin
                    n.st                   = bcc_pkg::ST_INS;
                    n.evt[`BCC_EV_REMOVED] = 1'b1;
                end
                else if (win_end)
                begin
                    // Top-off cycle keeps the charging flag low
                    if (ctl.en)
                    begin
                        n.st  = bcc_pkg::ST_PRE;
                        n.tmr = '0;
                        n.acc = '0;
                    end
                    else
                        n.st = bcc_pkg::ST_DONE;
                end
            end
            bcc_pkg::ST_INS:
            begin
                if (win_end)
                begin
                    if (vbat_lt_rch)
                    begin
                        n.st                    = bcc_pkg::ST_IDLE;
                        n.evt[`BCC_EV_INSERTED] = 1'b1;
                    end
                    else
                        n.st = bcc_pkg::ST_FULL;
                end
            end
            bcc_pkg::ST_FULL:
            begin
                if (!vbat_gt_lowv)
                    n.st = bcc_pkg::ST_INS;
                else if (win_end)
                    n.st = bcc_pkg::ST_DONE;
            end
            default:
            begin
                n.st   = bcc_pkg::ST_IDLE;
                n.flag = 1'b0;
            end
        endcase
        if (!ctl.en && (s.st inside {bcc_pkg::ST_SC, bcc_pkg::ST_PRE,
                                     bcc_pkg::ST_FAST, bcc_pkg::ST_CV}))
        begin
            n.st   = bcc_pkg::ST_IDLE;
            n.flag = 1'b0;
        end
        if (n.st != s.st)
            n.win = '0;
        // Timer advances at the ratio of actual to set current
        if (s.st inside {bcc_pkg::ST_PRE, bcc_pkg::ST_FAST})
        begin
            if (acc_sum >= 6'h10)
            begin
                n.acc = 5'(acc_sum - 6'h10);
                n.tmr = s.tmr + 16'h0001;
            end
            else
                n.acc = acc_sum[4:0];
        end
        n.sc_src = (n.st == bcc_pkg::ST_SC);
        n.q2_src = (n.st == bcc_pkg::ST_INS);
        n.sink   = (n.st inside {bcc_pkg::ST_DET, bcc_pkg::ST_FULL});
        n.chg_on = (n.st inside {bcc_pkg::ST_PRE, bcc_pkg::ST_FAST, bcc_pkg::ST_CV});
        n.cv     = (n.st == bcc_pkg::ST_CV);
        n.reduce = loops;
        n.term   = term_lvl;
        if (n.st == bcc_pkg::ST_PRE)
            n.cur = loops ? (pre_lvl >> 1) : pre_lvl;
        else if (n.chg_on)
            n.cur = fast_lvl;
        else
            n.cur = '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s    <= '0;
            s.st <= bcc_pkg::ST_IDLE;
        end
        else
            s <= n;
    end

    assign ctl.evt   = s.evt;
    assign ctl.stat  = {6'h00, s.flag, s.st};
    assign ctl.timer = s.tmr;

    assign sc_test_src         = s.sc_src;
    assign battery_path_switch = s.q2_src;
    assign detect_sink_current = s.sink;
    assign charge_on           = s.chg_on;
    assign cv_hold             = s.cv;
    assign cur_reduce          = s.reduce;
    assign cur_code            = s.cur;
    assign term_code           = s.term;
    assign ilim_500            = ctl.ilim_500;
    assign charging_flag       = s.flag;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Registered state lags its cause by one edge, so causes are read through $past

    a_sc_test_first: assert property (
        (s.st == bcc_pkg::ST_SC) ##1 (s.st == bcc_pkg::ST_PRE) |-> $past(vbat_gt_sc))
        else $error("charge started without short test pass");

    a_phase_order: assert property (
        $rose(s.st == bcc_pkg::ST_CV) |-> $past(s.st) == bcc_pkg::ST_FAST)
        else $error("constant voltage entered not from fast charge");

    a_fast_level: assert property (
        (s.st == bcc_pkg::ST_FAST && $stable(ctl.scale)) |-> s.cur == fast_lvl)
        else $error("fast charge level wrong");

    a_cv_hold_on: assert property (
        (s.st == bcc_pkg::ST_CV) |-> (s.cv && s.chg_on && !s.sink))
        else $error("constant voltage phase not held");

    a_term_blocked: assert property (
        (s.st == bcc_pkg::ST_CV && loops) |=> s.st != bcc_pkg::ST_DONE)
        else $error("termination while current was reduced");

    a_lowin_hold: assert property (
        (s.st == bcc_pkg::ST_CV && low_input_loop) |=> s.reduce && s.st != bcc_pkg::ST_DONE)
        else $error("termination during low input loop");

    a_loop_reduce: assert property (
        (tj_hot || load_priority_mode) |=> s.reduce)
        else $error("charge current not reduced");

    a_timer_slowed: assert property (
        (s.st == bcc_pkg::ST_FAST && chg_ratio == 5'h00) |=> $stable(s.tmr))
        else $error("timer ran with no charge current");

    a_pre_halved: assert property (
        (s.st == bcc_pkg::ST_PRE && $past(loops) && $stable(ctl.pre_sel) && $stable(ctl.scale))
            |-> s.cur == (pre_lvl >> 1))
        else $error("pre-charge level not reduced under a loop");

    a_term_unscaled: assert property (
        ($stable(ctl.term_sel) && $stable(ctl.scale) && loops) |-> s.term == term_lvl)
        else $error("termination level scaled by loop");

    a_detect_sink: assert property (
        $rose(s.st == bcc_pkg::ST_DET) |-> s.sink && $past(rch_dg))
        else $error("detection began without sink or recharge level");

    a_topoff_enabled: assert property (
        (s.st == bcc_pkg::ST_DET) ##1 (s.st == bcc_pkg::ST_PRE) |-> $past(ctl.en))
        else $error("top-off started while charging disabled");

    a_recharge_flag: assert property (
        (s.st == bcc_pkg::ST_DET) ##1 (s.st == bcc_pkg::ST_PRE) |-> !s.flag)
        else $error("recharge raised charging flag");

    a_removed_src: assert property (
        (s.st == bcc_pkg::ST_DET && !vbat_gt_lowv) |=> (s.st == bcc_pkg::ST_INS) ##0 s.q2_src)
        else $error("removal did not start insertion check");

    a_window_len: assert property (
        (s.st == bcc_pkg::ST_INS && win_end && !vbat_lt_rch) |=> s.st == bcc_pkg::ST_FULL)
        else $error("full battery check not started");

    a_full_removed: assert property (
        (s.st == bcc_pkg::ST_FULL && !vbat_gt_lowv) |=> s.st == bcc_pkg::ST_INS)
        else $error("no battery not declared in full check");

    // A filtered level may only follow a raw level that has held for two samples at least

    a_lowv_filtered: assert property (
        $changed(lowv_dg) |-> $past(vbat_gt_lowv) == lowv_dg && $past(vbat_gt_lowv, 2) == lowv_dg)
        else $error("pre-charge crossing passed unfiltered");

    a_rch_filtered: assert property (
        $changed(rch_dg) |-> $past(vbat_lt_rch) == rch_dg && $past(vbat_lt_rch, 2) == rch_dg)
        else $error("recharge level passed unfiltered");

    a_done_on_term: assert property (
        (s.st == bcc_pkg::ST_CV) ##1 (s.st == bcc_pkg::ST_DONE) |-> $past(ibat_lt_term && !loops))
        else $error("charge completed without termination current");
endmodule // bcc_charge_ctrl

// file: verification/bcc_cell_model.sv
// Behavioural battery cell and its slot as seen through the comparators
`timescale 1ns/100ps
module bcc_cell_model #(
    parameter int V_SC   = 1500,
    parameter int V_LOWV = 3000,
    parameter int V_REG  = 4200,
    parameter int V_RCH  = 4100,
    parameter int V_OPEN = 4400,
    parameter int TAPER  = 20
) (
    // Clock and scenario control
    input  wire logic        ref_clk,
    input  wire logic        present,
    input  wire logic [12:0] vset,
    input  wire logic [7:0]  slew,
    // Controls from the charger
    input  wire logic        sc_test_src,
    input  wire logic        battery_path_switch,
    input  wire logic        detect_sink_current,
    input  wire logic        cv_hold,
    // Comparators
    output logic             vbat_gt_sc,
    output logic             vbat_gt_lowv,
    output logic             vbat_ge_reg,
    output logic             vbat_lt_rch,
    output logic             ibat_lt_term
);
    int mv = 0;
    int tgt;
    int cv_cnt = 0;

    // An empty slot with nothing sourcing into it decays, it never keeps its last level
    always_comb
    begin
        if (present)
            tgt = vset;
        else if (sc_test_src || battery_path_switch)
            tgt = V_OPEN;
        else
            tgt = 0;
    end

    // With no cell fitted a sourced pin charges only its own capacitance, so it jumps
    always @(posedge ref_clk)
    begin
        if (!present && mv < tgt)
            mv <= tgt;
        else if (mv < tgt)
            mv <= (tgt - mv > slew) ? mv + slew : tgt;
        else
            mv <= (mv - tgt > slew) ? mv - slew : tgt;
        cv_cnt <= cv_hold ? cv_cnt + 1 : 0;
    end

    assign vbat_gt_sc   = mv > V_SC;
    assign vbat_gt_lowv = mv > V_LOWV;
    assign vbat_ge_reg  = mv >= V_REG;
    assign vbat_lt_rch  = mv < V_RCH;
    // Current tapers only after the voltage has been held for a while
    assign ibat_lt_term = cv_cnt >= TAPER;
endmodule // bcc_cell_model

// file: verification/testbench.sv
// Self-checking testbench for the battery charge control block
`timescale 1ns/100ps
`include "bcc_params.svh"
module testbench;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        tj_hot = 1'b0;
    logic        load_priority_mode = 1'b0;
    logic        low_input_loop = 1'b0;
    logic        present = 1'b1;
    logic [4:0]  chg_ratio = 5'h00;
    logic [12:0] vset = 13'h03e8;
    logic [7:0]  slew = 8'hff;
    logic [15:0] reg_rdata, d, ctrl, tm;
    logic [4:0]  cur_code, term_code;
    logic        irq, vbat_gt_sc, vbat_gt_lowv, vbat_ge_reg, vbat_lt_rch, ibat_lt_term;
    logic        sc_test_src, battery_path_switch, detect_sink_current, charge_on;
    logic        cv_hold, cur_reduce, ilim_500, charging_flag;
    int          fails = 0;
    int          cmp_count = 0;
    int          seed = 32'hd810_45b6;
    int          fast, pre, term, r;

    always #12.5 ref_clk = ~ref_clk;

    bcc_charge_ctrl #(.LOWV_CYC(8), .RCH_CYC(8), .DET_CYC(16)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .vbat_gt_sc(vbat_gt_sc), .vbat_gt_lowv(vbat_gt_lowv), .vbat_ge_reg(vbat_ge_reg),
        .vbat_lt_rch(vbat_lt_rch), .ibat_lt_term(ibat_lt_term), .tj_hot(tj_hot),
        .load_priority_mode(load_priority_mode), .low_input_loop(low_input_loop),
        .chg_ratio(chg_ratio), .sc_test_src(sc_test_src),
        .battery_path_switch(battery_path_switch), .detect_sink_current(detect_sink_current),
        .charge_on(charge_on), .cv_hold(cv_hold), .cur_reduce(cur_reduce),
        .cur_code(cur_code), .term_code(term_code), .ilim_500(ilim_500),
        .charging_flag(charging_flag));

    bcc_cell_model cell_u (
        .ref_clk(ref_clk), .present(present), .vset(vset), .slew(slew),
        .sc_test_src(sc_test_src), .battery_path_switch(battery_path_switch),
        .detect_sink_current(detect_sink_current), .cv_hold(cv_hold),
        .vbat_gt_sc(vbat_gt_sc), .vbat_gt_lowv(vbat_gt_lowv), .vbat_ge_reg(vbat_ge_reg),
        .vbat_lt_rch(vbat_lt_rch), .ibat_lt_term(ibat_lt_term));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so take them there
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task wait_st(input string nm, input logic [8:0] st);
        int n;
        n = 0;
        d = 16'h0000;
        while (d[8:0] !== st && n < 400)
        begin
            rd(`BCC_A_STAT, d);
            n++;
        end
        chk(nm, 16'(st), 16'(d[8:0]));
    endtask

    task done_test(input string nm);
        $display("Test %s finished, %0d mismatches so far", nm, fails);
    endtask

    task close_out;
        $display("Counts: %0d compared, %0d mismatched", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles; allow ample margin
    initial
    begin
        #(20000 * 25);
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        close_out;
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk("ilim_500 reset", 16'h0001, 16'(ilim_500));
        chk("irq reset", 16'h0000, 16'(irq));
        rd(`BCC_A_CTRL, d);
        chk("ctrl reset", `BCC_CTRL_RST, d);
        rd(`BCC_A_MASK, d);
        chk("mask reset", 16'h0000, d);
        wr(`BCC_A_STAT, 16'hffff);
        rd(8'h14, d);
        chk("unmapped read", 16'h0000, d);
        wait_st("idle", bcc_pkg::ST_IDLE);
        done_test("reset");

        ctrl = (16'({$random(seed)}) & 16'h00fe) | 16'h0001;
        fast = (ctrl[6:5] + 1) * 4;
        pre = fast >> (4 - ctrl[2:1]);
        term = fast >> (4 - ctrl[4:3]);
        @(posedge ref_clk);
        chg_ratio <= 5'({$random(seed)} % 17);
        wr(`BCC_A_MASK, 16'h0001);
        wr(`BCC_A_CTRL, ctrl);
        wait_st("short test", bcc_pkg::ST_SC);
        chk("short source", 16'h0001, 16'(sc_test_src));
        chk("charge held off", 16'h0000, 16'(charge_on));
        chk("flag at start", 16'h0001, 16'(charging_flag));
        chk("ilim field", 16'(ctrl[7]), 16'(ilim_500));
        rd(`BCC_A_IRQ, d);
        chk("start event", 16'h0008, d & 16'h0008);
        wr(`BCC_A_IRQ, 16'h0008);
        @(posedge ref_clk);
        vset <= 13'h07d0;
        wait_st("precharge", bcc_pkg::ST_PRE);
        chk("pre current", 16'(pre), 16'(cur_code));
        chk("term level", 16'(term), 16'(term_code));
        @(posedge ref_clk);
        tj_hot <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("pre hot", 16'(pre >> 1), 16'(cur_code));
        chk("reduce hot", 16'h0001, 16'(cur_reduce));
        chk("term hot", 16'(term), 16'(term_code));
        @(posedge ref_clk);
        tj_hot <= 1'b0;
        vset <= 13'h0dac;
        repeat (6) @(posedge ref_clk);
        vset <= 13'h07d0;
        repeat (4) @(posedge ref_clk);
        rd(`BCC_A_STAT, d);
        chk("glitch ignored", 16'(bcc_pkg::ST_PRE), 16'(d[8:0]));
        @(posedge ref_clk);
        vset <= 13'h0dac;
        wait_st("fast", bcc_pkg::ST_FAST);
        chk("fast current", 16'(fast), 16'(cur_code));
        r = {$random(seed)} % 16 + 1;
        @(posedge ref_clk);
        chg_ratio <= 5'(r);
        rd(`BCC_A_TIMER, tm);
        repeat (30) @(posedge ref_clk);
        rd(`BCC_A_TIMER, d);
        chk("timer rate", 16'(tm + 2 * r), d);
        @(posedge ref_clk);
        slew <= 8'h14;
        vset <= 13'h1068;
        load_priority_mode <= 1'b1;
        wait_st("cv", bcc_pkg::ST_CV);
        chk("cv hold", 16'h0001, 16'(cv_hold));
        repeat (40) @(posedge ref_clk);
        rd(`BCC_A_STAT, d);
        chk("no term in load", 16'(bcc_pkg::ST_CV), 16'(d[8:0]));
        @(posedge ref_clk);
        load_priority_mode <= 1'b0;
        low_input_loop <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(`BCC_A_STAT, d);
        chk("no term low in", 16'(bcc_pkg::ST_CV), 16'(d[8:0]));
        @(posedge ref_clk);
        low_input_loop <= 1'b0;
        wait_st("done", bcc_pkg::ST_DONE);
        repeat (2) @(posedge ref_clk);
        #1 chk("charger off", 16'h0000, 16'(charge_on));
        chk("irq done", 16'h0001, 16'(irq));
        wr(`BCC_A_IRQ, 16'h0001);
        repeat (3) @(posedge ref_clk);
        #1 chk("irq cleared", 16'h0000, 16'(irq));
        done_test("charge cycle");

        @(posedge ref_clk);
        vset <= 13'h0fa0;
        chg_ratio <= 5'h00;
        wait_st("detect", bcc_pkg::ST_DET);
        chk("detect sink", 16'h0001, 16'(detect_sink_current));
        // The cell is above the pre-charge level, so top-off leaves pre-charge after one cycle
        wait_st("top off", bcc_pkg::ST_FAST);
        chk("recharge flag", 16'h0000, 16'(charging_flag));
        wr(`BCC_A_CTRL, ctrl & 16'hfffe);
        wait_st("disabled", bcc_pkg::ST_IDLE);
        chk("off when disabled", 16'h0000, 16'(charge_on));
        done_test("recharge");

        @(posedge ref_clk);
        vset <= 13'h1068;
        wr(`BCC_A_CTRL, ctrl);
        wait_st("done again", bcc_pkg::ST_DONE);
        wr(`BCC_A_IRQ, 16'h000f);
        @(posedge ref_clk);
        present <= 1'b0;
        slew <= 8'hff;
        wait_st("removed", bcc_pkg::ST_INS);
        chk("insert source", 16'h0001, 16'(battery_path_switch));
        rd(`BCC_A_IRQ, d);
        chk("removed event", 16'h0002, d & 16'h0002);
        wait_st("full check", bcc_pkg::ST_FULL);
        chk("full sink", 16'h0001, 16'(detect_sink_current));
        wait_st("check again", bcc_pkg::ST_INS);
        @(posedge ref_clk);
        present <= 1'b1;
        vset <= 13'h07d0;
        wait_st("inserted", bcc_pkg::ST_PRE);
        chk("new cycle flag", 16'h0001, 16'(charging_flag));
        rd(`BCC_A_IRQ, d);
        chk("inserted event", 16'h0004, d & 16'h0004);
        done_test("removal");
        close_out;
    end
endmodule // testbench
